/* rbc_pkg.sv */
// Constants and types for the receiver baseband configuration bank.
// Assumes a single 100 MHz system clock and a byte-wide register port.
// Operation
// - An unsynchronised self-polling run ends when the timeout timer expires.
// - The timeout lasts the timer value times 64 times 512 clock periods.
// - A timer value of zero counts as 256 and one is the shortest timeout.
// - The two-bit corner field picks 40, 13.6, 5 or 3.6 kHz anti-aliasing.
// - The invert bit flips the recovered data polarity when it is one.
// - The sampling strobe comes every divider value plus one clock cycles.
// - The strength detector starts the programmed number plus one bits after frame sync.
// - The CIC input scale comes from bits 5:3 and should stay at zero.
// - The CIC comb delay is the three-bit field in bits 2:0 plus one.
// - The run-mode detector compares the signal level with a six-bit threshold.
package rbc_pkg;
  localparam logic [7:0] ADDR_TIMEOUT = 8'h6B;
  localparam logic [7:0] ADDR_GLOBALS_A = 8'h6C;
  localparam logic [7:0] ADDR_DIVIDER_A = 8'h6D;
  localparam logic [7:0] ADDR_START_DELAY_A = 8'h6E;
  localparam logic [7:0] ADDR_SCALE_DELAY_A = 8'h6F;
  localparam logic [7:0] ADDR_DECIMATION_A = 8'h70;
  localparam logic [7:0] ADDR_DETECTOR_A = 8'h71;
  localparam logic [7:0] ADDR_GLOBALS_B = 8'h8C;
  localparam logic [7:0] ADDR_DIVIDER_B = 8'h8D;
  localparam logic [7:0] ADDR_START_DELAY_B = 8'h8E;
  localparam logic [7:0] ADDR_SCALE_DELAY_B = 8'h8F;
  localparam logic [7:0] ADDR_DECIMATION_B = 8'h90;
  localparam logic [7:0] ADDR_DETECTOR_B = 8'h91;
  localparam logic [7:0] ADDR_MODE_CTRL = 8'hC0;
  localparam logic [7:0] ADDR_STATUS = 8'hC1;

  localparam logic [7:0] RESET_TIMEOUT = 8'hFF;
  localparam logic [7:0] RESET_CFG_BYTE = 8'h00;
  localparam logic [7:0] RESET_MODE_CTRL = 8'h00;

  localparam int MODE_TIMER_EN_BIT = 0;
  localparam int MODE_CFG_SEL_BIT = 1;
  localparam int DATA_INVERT_BIT = 0;
  localparam int CORNER_LSB = 1;
  localparam int SCALE_LSB = 3;
  localparam int COMB_LSB = 0;
  localparam int THR_CNT_LSB = 6;
  localparam int THR_LVL_LSB = 0;

  // Timeout prescale, in system clock periods per timer step
  localparam int TIMEOUT_FACTOR_A = 64;
  localparam int TIMEOUT_FACTOR_B = 512;
  localparam int TIMEOUT_TICK_CYCLES = TIMEOUT_FACTOR_A * TIMEOUT_FACTOR_B;
  localparam logic [8:0] TIMEOUT_ZERO_LIMIT = 9'h100;

  typedef enum logic [1:0] {
    RBC_CORNER_40K,
    RBC_CORNER_13K6,
    RBC_CORNER_5K,
    RBC_CORNER_3K6
  } rbc_corner_t;

  typedef struct packed {
    logic [7:0] globals;
    logic [7:0] divider;
    logic [7:0] start_delay;
    logic [7:0] scale_delay;
    logic [7:0] decimation;
    logic [7:0] detector;
  } rbc_cfg_t;

  typedef struct packed {
    logic [7:0] timeout_value;
    logic [7:0] mode_ctrl;
    rbc_cfg_t [1:0] cfg;
    logic [15:0] pre_cnt;
    logic [8:0] tick_cnt;
    logic [7:0] sample_cnt;
    logic [7:0] bit_cnt;
    logic armed;
    logic timer_running;
    logic polling_timeout;
    logic sample_strobe;
    logic data_out;
    rbc_corner_t corner;
    logic [2:0] cic_scale;
    logic [3:0] cic_delay;
    logic [5:0] cic_decim;
    logic [1:0] thr_counter;
    logic strength_enable;
    logic signal_detected;
    logic cfg_b_active;
    logic [7:0] rdata;
  } rbc_state_t;
endpackage : rbc_pkg

/* rbc_config_bank.sv */
// Configuration bank and small baseband helpers for the receiver.
// Assumes all inputs come from logic on sys_clk; registers sit on a
// plain byte port with read data one cycle after the read strobe.
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

module rbc_config_bank #(
  parameter int TICK_CYCLES = rbc_pkg::TIMEOUT_TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic run_mode,
  input wire logic symbol_sync,
  input wire logic frame_sync_point,
  input wire logic bit_strobe,
  input wire logic rx_data,
  input wire logic [5:0] signal_level,
  output logic polling_timeout,
  output logic timer_running,
  output logic sample_strobe,
  output logic data_out,
  output logic [1:0] antialias_corner_select,
  output logic [2:0] cic_input_scale,
  output logic [3:0] cic_comb_delay,
  output logic [5:0] cic_decimation_factor,
  output logic [1:0] detector_threshold_counter,
  output logic strength_enable,
  output logic signal_detected,
  output logic cfg_b_active
);

  // Prescale step end, cut to the counter width
  localparam logic [15:0] TICK_LAST = 16'(TICK_CYCLES - 1);

  rbc_pkg::rbc_state_t st;
  rbc_pkg::rbc_state_t next_st;

  // Working values for the active copy
  rbc_pkg::rbc_cfg_t act;
  logic [8:0] limit;
  logic [7:0] status;
  logic run_timer;

  // Next state of the whole block
  always_comb begin
    next_st = st;
    act = st.cfg[st.mode_ctrl[rbc_pkg::MODE_CFG_SEL_BIT]];
    if (st.timeout_value == 8'h00) begin
      limit = rbc_pkg::TIMEOUT_ZERO_LIMIT;
    end else begin
      limit = {1'b0, st.timeout_value};
    end
    run_timer = st.mode_ctrl[rbc_pkg::MODE_TIMER_EN_BIT] & run_mode & ~symbol_sync;
    status = {4'h0, st.signal_detected, st.strength_enable, st.cfg_b_active, st.timer_running};

    // Register writes
    if (wr) begin
      unique case (addr)
        rbc_pkg::ADDR_TIMEOUT: begin
          next_st.timeout_value = wdata;
        end
        rbc_pkg::ADDR_MODE_CTRL: begin
          next_st.mode_ctrl = wdata;
        end
        rbc_pkg::ADDR_GLOBALS_A: begin
          next_st.cfg[0].globals = wdata;
        end
        rbc_pkg::ADDR_DIVIDER_A: begin
          next_st.cfg[0].divider = wdata;
        end
        rbc_pkg::ADDR_START_DELAY_A: begin
          next_st.cfg[0].start_delay = wdata;
        end
        rbc_pkg::ADDR_SCALE_DELAY_A: begin
          next_st.cfg[0].scale_delay = wdata;
        end
        rbc_pkg::ADDR_DECIMATION_A: begin
          next_st.cfg[0].decimation = wdata;
        end
        rbc_pkg::ADDR_DETECTOR_A: begin
          next_st.cfg[0].detector = wdata;
        end
        rbc_pkg::ADDR_GLOBALS_B: begin
          next_st.cfg[1].globals = wdata;
        end
        rbc_pkg::ADDR_DIVIDER_B: begin
          next_st.cfg[1].divider = wdata;
        end
        rbc_pkg::ADDR_START_DELAY_B: begin
          next_st.cfg[1].start_delay = wdata;
        end
        rbc_pkg::ADDR_SCALE_DELAY_B: begin
          next_st.cfg[1].scale_delay = wdata;
        end
        rbc_pkg::ADDR_DECIMATION_B: begin
          next_st.cfg[1].decimation = wdata;
        end
        rbc_pkg::ADDR_DETECTOR_B: begin
          next_st.cfg[1].detector = wdata;
        end
        default: begin
          next_st.mode_ctrl = st.mode_ctrl; // Unmapped write ignored
        end
      endcase
    end

    // Read data: status and mode control read back, the rest read zero
    if (rd && addr == rbc_pkg::ADDR_STATUS) begin
      next_st.rdata = status;
    end else if (rd && addr == rbc_pkg::ADDR_MODE_CTRL) begin
      next_st.rdata = st.mode_ctrl;
    end else begin
      next_st.rdata = 8'h00;
    end

    // Timeout timer: value steps of 64 x 512 cycles
    next_st.polling_timeout = 1'b0;
    next_st.timer_running = run_timer;
    if (!run_timer) begin
      next_st.pre_cnt = 16'h0000;
      next_st.tick_cnt = 9'h000;
    end else if (st.pre_cnt == TICK_LAST) begin
      next_st.pre_cnt = 16'h0000;
      if (st.tick_cnt + 9'h001 == limit) begin
        next_st.polling_timeout = 1'b1;
        next_st.tick_cnt = 9'h000;
      end else begin
        next_st.tick_cnt = st.tick_cnt + 9'h001;
      end
    end else begin
      next_st.pre_cnt = st.pre_cnt + 16'h0001;
    end

    next_st.sample_strobe = 1'b0;
    if (st.sample_cnt >= act.divider) begin
      next_st.sample_cnt = 8'h00;
      next_st.sample_strobe = 1'b1;
    end else begin
      next_st.sample_cnt = st.sample_cnt + 8'h01;
    end

    next_st.data_out = rx_data ^ act.globals[rbc_pkg::DATA_INVERT_BIT];

    next_st.corner = rbc_pkg::rbc_corner_t'(act.globals[rbc_pkg::CORNER_LSB +: 2]);

    next_st.cic_scale = act.scale_delay[rbc_pkg::SCALE_LSB +: 3];

    next_st.cic_delay = {1'b0, act.scale_delay[rbc_pkg::COMB_LSB +: 3]} + 4'h1;

    // Decimation passed on as written
    next_st.cic_decim = act.decimation[5:0];

    // Threshold counter passed on as written
    next_st.thr_counter = act.detector[rbc_pkg::THR_CNT_LSB +: 2];

    next_st.signal_detected = signal_level >= act.detector[rbc_pkg::THR_LVL_LSB +: 6];

    if (frame_sync_point) begin
      next_st.bit_cnt = 8'h00;
      next_st.armed = 1'b1;
      next_st.strength_enable = 1'b0;
    end else if (bit_strobe && st.armed) begin
      if (st.bit_cnt == act.start_delay) begin
        next_st.strength_enable = 1'b1;
        next_st.armed = 1'b0;
      end else begin
        next_st.bit_cnt = st.bit_cnt + 8'h01;
      end
    end

    next_st.cfg_b_active = st.mode_ctrl[rbc_pkg::MODE_CFG_SEL_BIT];
  end

  // State register
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.timeout_value <= rbc_pkg::RESET_TIMEOUT;
      st.mode_ctrl <= rbc_pkg::RESET_MODE_CTRL;
      st.cfg <= {12{rbc_pkg::RESET_CFG_BYTE}};
      st.corner <= rbc_pkg::RBC_CORNER_40K;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from state flops
  assign rdata = st.rdata;
  assign polling_timeout = st.polling_timeout;
  assign timer_running = st.timer_running;
  assign sample_strobe = st.sample_strobe;
  assign data_out = st.data_out;
  assign antialias_corner_select = st.corner;
  assign cic_input_scale = st.cic_scale;
  assign cic_comb_delay = st.cic_delay;
  assign cic_decimation_factor = st.cic_decim;
  assign detector_threshold_counter = st.thr_counter;
  assign strength_enable = st.strength_enable;
  assign signal_detected = st.signal_detected;
  assign cfg_b_active = st.cfg_b_active;

endmodule // rbc_config_bank

`default_nettype wire

/* rbc_config_bank_properties.sv */
// Port-level checks for the receiver configuration bank.
// Assumes binding to rbc_config_bank with rst active high.
`timescale 1ns/1ps
`default_nettype none
module rbc_config_bank_properties #(
  parameter int TICK_CYCLES = rbc_pkg::TIMEOUT_TICK_CYCLES
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [7:0] addr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic run_mode,
  input wire logic symbol_sync,
  input wire logic frame_sync_point,
  input wire logic bit_strobe,
  input wire logic [5:0] signal_level,
  input wire logic polling_timeout,
  input wire logic timer_running,
  input wire logic [3:0] cic_comb_delay,
  input wire logic strength_enable,
  input wire logic signal_detected,
  input wire logic cfg_b_active
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Config bytes never read back
  a_wo_read_zero: assert property ($past(rd) && $past(addr) < 8'hC0 |-> rdata == 8'h00)
    else $error("write-only read not zero");
  a_timeout_once: assert property (polling_timeout |=> !polling_timeout)
    else $error("timeout pulse too long");
  a_timeout_cause: assert property (polling_timeout |-> $past(timer_running))
    else $error("timeout without running timer");
  a_timer_gate: assert property (timer_running |-> $past(run_mode) && !$past(symbol_sync))
    else $error("timer runs outside run mode");
  a_comb_range: assert property (!$past(rst) |-> cic_comb_delay inside {[4'h1:4'h8]})
    else $error("comb delay out of range");
  a_strength_clear: assert property (frame_sync_point |=> !strength_enable)
    else $error("strength not cleared by sync");
  a_strength_bit: assert property ($rose(strength_enable) |-> $past(bit_strobe))
    else $error("strength start without bit");
  a_detect_max: assert property ($past(signal_level) == 6'h3F |-> signal_detected)
    else $error("full level not detected");
  // Main scenarios reached
  cover property (polling_timeout);
  cover property ($rose(strength_enable));
  cover property (cfg_b_active && signal_detected);
endmodule // rbc_config_bank_properties
`default_nettype wire

/* rbc_config_bank_tb_top.sv */
// Self-checking bench for the receiver configuration bank.
// Assumes the checker module is compiled beside it.
`timescale 1ns/1ps
`default_nettype none
module rbc_config_bank_tb_top;
  localparam int T = 4;
  logic sys_clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, run_mode = 1'b0, symbol_sync = 1'b0;
  logic frame_sync_point = 1'b0, bit_strobe = 1'b0, rx_data = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v [4], r;
  logic [5:0] signal_level = 6'h00;
  logic polling_timeout, timer_running, sample_strobe, data_out, strength_enable, signal_detected, cfg_b_active;
  logic [1:0] antialias_corner_select, detector_threshold_counter;
  logic [2:0] cic_input_scale;
  logic [3:0] cic_comb_delay;
  logic [5:0] cic_decimation_factor;
  int n_mismatch = 0, total_checks = 0, n, p [4], d;
  rbc_config_bank #(.TICK_CYCLES(T)) i_rbc_config_bank (.sys_clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
    .run_mode, .symbol_sync, .frame_sync_point, .bit_strobe, .rx_data, .signal_level, .polling_timeout,
    .timer_running, .sample_strobe, .data_out, .antialias_corner_select, .cic_input_scale, .cic_comb_delay,
    .cic_decimation_factor, .detector_threshold_counter, .strength_enable, .signal_detected, .cfg_b_active);
  always #5 sys_clk = ~sys_clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [7:0] a, input logic [7:0] dt);
    @(posedge sys_clk) {addr, wdata, wr} <= {a, dt, 1'b1};
    @(posedge sys_clk) wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, output logic [7:0] dt);
    @(posedge sys_clk) {addr, rd} <= {a, 1'b1};
    @(posedge sys_clk) rd <= 1'b0;
    #1 dt = rdata;
  endtask
  // Cycles until the next strobe or timeout pulse
  task automatic waitp(input bit s, output int c);
    c = 0;
    do begin
      @(posedge sys_clk);
      #1 c++;
    end while ((s ? polling_timeout : sample_strobe) !== 1'b1 && c < 2000);
  endtask
  // Drive datapath inputs and compare decoded fields
  task automatic cfgchk(input logic [7:0] g, input logic [7:0] s, input logic [7:0] dc, input logic [7:0] t);
    logic x;
    logic [5:0] l;
    x = 1'($urandom);
    // Full-scale level against the top threshold
    l = (t[5:0] == 6'h3F) ? 6'h3F : 6'($urandom);
    @(posedge sys_clk) {rx_data, signal_level} <= {x, l};
    repeat (3) @(posedge sys_clk);
    #1 chk(antialias_corner_select, g[2:1]);
    chk(data_out, g[0] ^ x);
    chk(cic_input_scale, s[5:3]);
    chk(cic_comb_delay, comb_exp(s));
    chk(cic_decimation_factor, dc[5:0]);
    chk(detector_threshold_counter, t[7:6]);
    chk(signal_detected, l >= t[5:0]);
  endtask
  // Expected timeout period in cycles for a timer value
  function automatic int tmo_cycles(input logic [7:0] tv);
    return ((tv == 8'h00) ? 256 : int'(tv)) * T;
  endfunction
  // Expected comb delay: field plus one
  function automatic logic [3:0] comb_exp(input logic [7:0] s);
    return {1'b0, s[2:0]} + 4'h1;
  endfunction
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge sys_clk);
    n_mismatch++;
    summarize();
  end
  initial begin
    void'($urandom(73947));
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    rreg(rbc_pkg::ADDR_MODE_CTRL, r);
    chk(r, rbc_pkg::RESET_MODE_CTRL);
    rreg(rbc_pkg::ADDR_TIMEOUT, r);
    chk(r, 8'h00);
    rreg(8'hFF, r);
    chk(r, 8'h00);
    $display("test reset done");
    for (int i = 0; i < 6; i++) begin
      for (int j = 0; j < 4; j++) v[j] = (i == 0) ? 8'hFF : 8'($urandom);
      v[3][7:6] = 2'b00;
      wreg(rbc_pkg::ADDR_GLOBALS_A, v[0]);
      wreg(rbc_pkg::ADDR_SCALE_DELAY_A, v[1]);
      wreg(rbc_pkg::ADDR_DECIMATION_A, v[2]);
      wreg(rbc_pkg::ADDR_DETECTOR_A, v[3]);
      cfgchk(v[0], v[1], v[2], v[3]);
    end
    $display("test fields done");
    wreg(rbc_pkg::ADDR_GLOBALS_B, ~v[0]);
    wreg(rbc_pkg::ADDR_SCALE_DELAY_B, ~v[1]);
    wreg(rbc_pkg::ADDR_DECIMATION_B, ~v[2]);
    wreg(rbc_pkg::ADDR_DETECTOR_B, ~v[3] & 8'h3F);
    cfgchk(v[0], v[1], v[2], v[3]);
    wreg(rbc_pkg::ADDR_MODE_CTRL, 8'h02);
    cfgchk(~v[0], ~v[1], ~v[2], ~v[3] & 8'h3F);
    rreg(rbc_pkg::ADDR_STATUS, r);
    chk(r[1], 1'b1);
    chk(cfg_b_active, 1'b1);
    wreg(rbc_pkg::ADDR_MODE_CTRL, 8'h00);
    $display("test config select done");
    for (int k = 0; k < 3; k++) begin
      d = (k == 0) ? 0 : (k == 1) ? 255 : $urandom % 20;
      // Last pass runs on copy B while A keeps 255
      if (k == 2) wreg(rbc_pkg::ADDR_MODE_CTRL, 8'h02);
      wreg((k == 2) ? rbc_pkg::ADDR_DIVIDER_B : rbc_pkg::ADDR_DIVIDER_A, 8'(d));
      waitp(1'b0, n);
      waitp(1'b0, n);
      chk(n, d + 1);
    end
    $display("test divider done");
    @(posedge sys_clk) run_mode <= 1'b1;
    repeat (10) @(posedge sys_clk);
    #1 chk(timer_running, 1'b0);
    @(posedge sys_clk) symbol_sync <= 1'b1;
    wreg(rbc_pkg::ADDR_MODE_CTRL, 8'h01);
    repeat (10) @(posedge sys_clk);
    #1 chk(timer_running, 1'b0);
    @(posedge sys_clk) symbol_sync <= 1'b0;
    rreg(rbc_pkg::ADDR_STATUS, r);
    chk(r[0], 1'b1);
    for (int k = 0; k < 4; k++) begin
      if (k > 0) wreg(rbc_pkg::ADDR_TIMEOUT, 8'(k % 3));
      waitp(1'b1, n);
      waitp(1'b1, p[k]);
    end
    chk(p[0], tmo_cycles(8'hFF));
    chk(p[1], tmo_cycles(8'h01));
    chk(p[2], tmo_cycles(8'h02));
    chk(p[3], tmo_cycles(8'h00));
    $display("test timeout done");
    for (int k = 0; k < 2; k++) begin
      d = (k == 0) ? 0 : $urandom % 5 + 1;
      // Second pass runs on copy B while A keeps zero
      if (k > 0) wreg(rbc_pkg::ADDR_MODE_CTRL, 8'h02);
      wreg((k == 0) ? rbc_pkg::ADDR_START_DELAY_A : rbc_pkg::ADDR_START_DELAY_B, 8'(d));
      @(posedge sys_clk) frame_sync_point <= 1'b1;
      @(posedge sys_clk) frame_sync_point <= 1'b0;
      for (int i = 0; i <= d; i++) begin
        repeat (2) @(posedge sys_clk);
        #1 chk(strength_enable, 1'b0);
        @(posedge sys_clk) bit_strobe <= 1'b1;
        @(posedge sys_clk) bit_strobe <= 1'b0;
      end
      @(posedge sys_clk);
      #1 chk(strength_enable, 1'b1);
    end
    rreg(rbc_pkg::ADDR_STATUS, r);
    chk(r[2], 1'b1);
    chk(cfg_b_active, 1'b1);
    $display("test strength start done");
    summarize();
  end
endmodule // rbc_config_bank_tb_top
bind rbc_config_bank rbc_config_bank_properties #(.TICK_CYCLES(TICK_CYCLES)) i_rbc_config_bank_properties (
  .sys_clk, .rst, .addr, .rd, .rdata, .run_mode, .symbol_sync, .frame_sync_point, .bit_strobe, .signal_level,
  .polling_timeout, .timer_running, .cic_comb_delay, .strength_enable, .signal_detected, .cfg_b_active);
`default_nettype wire
